/* inc/ccc_pkg.sv */
// ---------------------------------------------------------------
// Calibration control constants
// ---------------------------------------------------------------
package ccc_pkg;
    // Converters served by the bank
    localparam int CCC_NCONV = 2;
    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_PAGE  = 8'h08;
    localparam logic [7:0] IDX_CTRL  = 8'h51;
    localparam logic [7:0] IDX_STAT  = 8'h52;
    localparam logic [7:0] IDX_FSC   = 8'h5A;
    localparam logic [7:0] IDX_TUNE  = 8'h61;
    localparam logic [7:0] IDX_CLKG  = 8'h81;
    localparam logic [7:0] IDX_OSC   = 8'h83;
    localparam logic [7:0] IDX_ISTAT = 8'hF0;
    localparam logic [7:0] IDX_IMASK = 8'hF1;
    // Field positions
    localparam int CTRL_RUN_EN_BIT = 7;
    localparam int CTRL_MODE_LSB   = 1;
    localparam int CTRL_GO_BIT     = 0;
    localparam int STAT_ACTIVE_BIT = 2;
    localparam int STAT_FAIL_BIT   = 1;
    localparam int STAT_DONE_BIT   = 0;
    localparam int TUNE_A_BIT      = 6;
    localparam int TUNE_B_BIT      = 5;
    localparam int TUNE_C_BIT      = 3;
    localparam int OSC_CTRL_BIT    = 7;
    // Values after reset
    localparam logic [7:0] CTRL_RST  = 8'h82;
    localparam logic [7:0] FSC_RST   = 8'h28;
    localparam logic [7:0] TUNE_RST  = 8'h60;
    localparam logic [7:0] CLKG_RST  = 8'h00;
    localparam logic [7:0] OSC_RST   = 8'h02;
    localparam logic [7:0] PAGE_RST  = 8'h03;
    localparam logic [7:0] IMASK_RST = 8'h00;
    // Ring oscillator divide ratios per select code
    localparam logic [5:0] OSC_DIV_00 = 6'h08;
    localparam logic [5:0] OSC_DIV_01 = 6'h10;
    localparam logic [5:0] OSC_DIV_10 = 6'h20;
    localparam logic [5:0] OSC_DIV_11 = 6'h20;
    // Gray coded run states, idle to run to done
    typedef enum logic [1:0] {
        CCC_IDLE = 2'h0,
        CCC_RUN  = 2'h1,
        CCC_DONE = 2'h3,
        CCC_FAIL = 2'h2
    } ccc_state_t;
endpackage : ccc_pkg

/* inc/ccc_conv_if.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Bank to per-converter channel
// ---------------------------------------------------------------
interface ccc_conv_if;
    logic [7:0] wdata;     // Bus write data, low byte
    logic       wr_ctrl;   // Write control copy
    logic       wr_fsc;    // Write full-scale copy
    logic       engine_en; // Engine out of reset
    logic       end_ok;    // Engine finished, one pulse
    logic       end_fail;  // Engine failed, one pulse
    logic [6:0] ctrl_q;    // Stored control bits
    logic [7:0] fsc_q;     // Stored full-scale code
    logic       active;    // Run in progress
    logic       done;      // Completion flag
    logic       fail;      // Failure flag
    logic       done_evt;  // Completion event pulse
    logic       fail_evt;  // Failure event pulse
    modport bank (output wdata, wr_ctrl, wr_fsc, engine_en,
                  end_ok, end_fail,
                  input  ctrl_q, fsc_q, active, done, fail,
                  done_evt, fail_evt);
    modport conv (input  wdata, wr_ctrl, wr_fsc, engine_en,
                  end_ok, end_fail,
                  output ctrl_q, fsc_q, active, done, fail,
                  done_evt, fail_evt);
endinterface : ccc_conv_if

/* design/ccc_conv.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Per-converter paged copy and run sequencer
// ---------------------------------------------------------------
module ccc_conv
    import ccc_pkg::*;
(
    input wire logic    clk,
    input wire logic    arst_n,
    ccc_conv_if.conv    ch
);
    ccc_state_t state;      // Run state
    ccc_state_t next_state; // Next run state
    logic       go;         // Launch request this cycle

    // launch on go, never in a disabling write
    assign go = ch.wr_ctrl & ch.wdata[CTRL_GO_BIT] & ch.engine_en
                & ch.wdata[CTRL_RUN_EN_BIT];

    // Control copy, go bit reads back as written
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ch.ctrl_q <= CTRL_RST[6:0];
        end else if (ch.wr_ctrl) begin
            ch.ctrl_q <= ch.wdata[6:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ch.fsc_q <= FSC_RST;
        end else if (ch.wr_fsc) begin
            ch.fsc_q <= ch.wdata;
        end
    end

    // Next state, a second go while running is ignored
    always_comb begin
        next_state = state;
        case (state)
            CCC_IDLE, CCC_DONE, CCC_FAIL: begin
                if (go) begin
                    next_state = CCC_RUN;
                end
            end
            CCC_RUN: begin
                // Failure wins when both ends arrive together
                if (ch.end_fail) begin
                    next_state = CCC_FAIL;
                end else if (ch.end_ok) begin
                    next_state = CCC_DONE;
                end
            end
            default: next_state = CCC_IDLE;
        endcase
    end

    // engine held in reset clears the run
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= CCC_IDLE;
        end else if (!ch.engine_en) begin
            state <= CCC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign ch.active   = (state == CCC_RUN);
    assign ch.done     = (state == CCC_DONE);
    assign ch.fail     = (state == CCC_FAIL);
    assign ch.done_evt = ch.active & ch.engine_en & ch.end_ok
                         & ~ch.end_fail;
    assign ch.fail_evt = ch.active & ch.engine_en & ch.end_fail;
endmodule : ccc_conv

/* design/ccc_top.sv */
`timescale 1ns/100ps
// Operation
// - Bit 7 low holds engine in reset
// - Go bit launches run on page
// - Active flag reads one while running
// - Failure flag reads one after failure
// - Done flag reads one after finish
// - Mode, go, status, code are paged
// - Eight-bit full-scale code, reset 0x28
// - Divide select 00 by 8, 01 by 16
module ccc_top
    import ccc_pkg::*;
#(
    parameter int NCONV = CCC_NCONV, // Converter count
    parameter int AW    = 12         // Bus address width
)(
    input  wire logic                 CLK,
    input  wire logic                 ARST_N,
    // AHB-Lite slave
    input  wire logic                 HSEL,
    input  wire logic [AW-1:0]        HADDR,
    input  wire logic [1:0]           HTRANS,
    input  wire logic                 HWRITE,
    input  wire logic [2:0]           HSIZE,
    input  wire logic [31:0]          HWDATA,
    input  wire logic                 HREADY,
    output logic      [31:0]          HRDATA,
    output logic                      HREADYOUT,
    output logic                      HRESP,
    // Calibration engine
    output logic                      ENGINE_RESET_N,
    output logic      [NCONV-1:0]     CAL_RUN,
    input  wire logic [NCONV-1:0]     CAL_END_OK,
    input  wire logic [NCONV-1:0]     CAL_END_FAIL,
    output logic      [2*NCONV-1:0]   CAL_MODE,
    output logic      [8*NCONV-1:0]   FSC_CODE,
    output logic      [2:0]           CAL_TUNE,
    output logic      [NCONV-1:0]     CALCLK_OFF,
    // Ring oscillator
    output logic                      OSC_CTRL,
    output logic      [5:0]           OSC_DIV,
    // Interrupt
    output logic                      IRQ
);
    // -----------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------
    logic             dp_wr;      // Write data phase pending
    logic             dp_rd;      // Read data phase pending
    logic             rd_done;    // Read data registered
    logic [7:0]       dp_idx;     // Register index of transfer
    logic             dp_map;     // Address in register window
    logic             ap_take;    // Address phase accepted
    logic             ap_map;     // Address decodes in window
    logic [7:0]       wb;         // Write data, low byte
    logic             run_en;     // Engine run enable
    logic [7:0]       page;       // Converter page select
    logic [7:0]       tune;       // Tuning register
    logic [7:0]       clkg;       // Clock gating register
    logic [7:0]       osc;        // Oscillator register
    logic [2*NCONV-1:0] istat;    // Sticky event bits
    logic [2*NCONV-1:0] imask;    // Interrupt mask
    logic [2*NCONV-1:0] ev_set;   // Events this cycle
    logic [2*NCONV-1:0] next_istat; // Next sticky bits
    logic [NCONV-1:0] ok_s1;      // Sync stage one
    logic [NCONV-1:0] ok_s2;      // Sync stage two
    logic [NCONV-1:0] ok_s3;      // Edge history
    logic [NCONV-1:0] fl_s1;      // Sync stage one
    logic [NCONV-1:0] fl_s2;      // Sync stage two
    logic [NCONV-1:0] fl_s3;      // Edge history
    logic [NCONV-1:0] c_active;   // Per converter active
    logic [NCONV-1:0] c_done;     // Per converter done
    logic [NCONV-1:0] c_fail;     // Per converter fail
    logic [7*NCONV-1:0] c_ctrl;   // Per converter control
    logic [8*NCONV-1:0] c_fsc;    // Per converter code
    logic [31:0]      next_rdata; // Read mux result
    logic             wr_go;      // Register write strobe

    // -----------------------------------------------------------
    // AHB-Lite slave
    // -----------------------------------------------------------

    // Transfer accepted on a non-idle, selected cycle
    assign ap_take = HSEL & HTRANS[1] & HREADY;

    // Only aligned words below the window top decode
    assign ap_map  = (HADDR[AW-1:10] == '0) & (HADDR[1:0] == 2'h0);

    // Reads stall one cycle so data comes from a flop
    // and never misses a write from the previous transfer
    assign HREADYOUT = ~(dp_rd & ~rd_done);

    // Response is always OKAY, unmapped reads give zero
    assign HRESP = 1'b0;

    // Data phase tracking
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dp_wr  <= 1'b0;
            dp_rd  <= 1'b0;
            dp_idx <= 8'h00;
            dp_map <= 1'b0;
        end else if (HREADY) begin
            dp_wr  <= ap_take & HWRITE;
            dp_rd  <= ap_take & ~HWRITE;
            dp_idx <= HADDR[9:2];
            dp_map <= ap_map;
        end
    end

    // Wait state marker for reads
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_done <= 1'b0;
        end else if (HREADY) begin
            rd_done <= 1'b0;
        end else begin
            rd_done <= dp_rd;
        end
    end

    // Write happens at the end of the data phase
    assign wr_go = dp_wr & dp_map;
    assign wb    = HWDATA[7:0];

    // -----------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------

    // Engine ends come from another domain
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ok_s1 <= '0;
            ok_s2 <= '0;
            ok_s3 <= '0;
            fl_s1 <= '0;
            fl_s2 <= '0;
            fl_s3 <= '0;
        end else begin
            ok_s1 <= CAL_END_OK;
            ok_s2 <= ok_s1;
            ok_s3 <= ok_s2;
            fl_s1 <= CAL_END_FAIL;
            fl_s2 <= fl_s1;
            fl_s3 <= fl_s2;
        end
    end

    // -----------------------------------------------------------
    // Global registers
    // -----------------------------------------------------------

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            run_en <= CTRL_RST[CTRL_RUN_EN_BIT];
        end else if (wr_go && dp_idx == IDX_CTRL) begin
            run_en <= wb[CTRL_RUN_EN_BIT];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            page <= PAGE_RST;
        end else if (wr_go && dp_idx == IDX_PAGE) begin
            page <= wb;
        end
    end

    // Tuning bits, reserved bits stored as written
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tune <= TUNE_RST;
        end else if (wr_go && dp_idx == IDX_TUNE) begin
            tune <= wb;
        end
    end

    // Calibration clock gating per converter
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            clkg <= CLKG_RST;
        end else if (wr_go && dp_idx == IDX_CLKG) begin
            clkg <= wb;
        end
    end

    // Oscillator register, bits 6 to 2 read as zero
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            osc <= OSC_RST;
        end else if (wr_go && dp_idx == IDX_OSC) begin
            osc <= {wb[OSC_CTRL_BIT], 5'h00, wb[1:0]};
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            OSC_DIV <= OSC_DIV_10;
        end else begin
            case (osc[1:0])
                2'h0:    OSC_DIV <= OSC_DIV_00;
                2'h1:    OSC_DIV <= OSC_DIV_01;
                2'h2:    OSC_DIV <= OSC_DIV_10;
                default: OSC_DIV <= OSC_DIV_11;
            endcase
        end
    end

    // -----------------------------------------------------------
    // Per-converter copies
    // -----------------------------------------------------------
    generate
        for (genvar i = 0; i < NCONV; i++) begin : g_conv
            ccc_conv_if ch ();

            assign ch.wr_ctrl   = wr_go & (dp_idx == IDX_CTRL)
                                  & page[i];
            assign ch.wr_fsc    = wr_go & (dp_idx == IDX_FSC)
                                  & page[i];
            assign ch.wdata     = wb;
            assign ch.engine_en = run_en;
            // Rising edges of the synchronised ends
            assign ch.end_ok    = ok_s2[i] & ~ok_s3[i];
            assign ch.end_fail  = fl_s2[i] & ~fl_s3[i];

            // Gather state for read mux and outputs
            assign c_active[i]      = ch.active;
            assign c_done[i]        = ch.done;
            assign c_fail[i]        = ch.fail;
            assign c_ctrl[7*i +: 7] = ch.ctrl_q;
            assign c_fsc[8*i +: 8]  = ch.fsc_q;
            assign ev_set[i]        = ch.done_evt;
            assign ev_set[NCONV+i]  = ch.fail_evt;

            ccc_conv u_conv (
                .clk    (CLK),
                .arst_n (ARST_N),
                .ch     (ch)
            );
        end
    endgenerate

    // -----------------------------------------------------------
    // Interrupt status and mask
    // -----------------------------------------------------------

    // Write one clears, a new event wins over its clear
    always_comb begin
        next_istat = istat;
        if (wr_go && dp_idx == IDX_ISTAT) begin
            next_istat = istat & ~wb[2*NCONV-1:0];
        end
        next_istat = next_istat | ev_set;
    end

    // Sticky event bits
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            istat <= '0;
        end else begin
            istat <= next_istat;
        end
    end

    // Mask, one enables the event
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            imask <= IMASK_RST[2*NCONV-1:0];
        end else if (wr_go && dp_idx == IDX_IMASK) begin
            imask <= wb[2*NCONV-1:0];
        end
    end

    // Level interrupt from a flop
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(next_istat & imask);
        end
    end

    // -----------------------------------------------------------
    // Read data
    // -----------------------------------------------------------

    // Paged read, lowest selected copy answers
    function automatic int unsigned rd_sel(input logic [7:0] pg);
        int unsigned s;
        s = 0;
        for (int k = NCONV - 1; k >= 0; k--) begin
            if (pg[k]) begin
                s = k;
            end
        end
        return s;
    endfunction : rd_sel

    // Read mux, unmapped reads zero, tuning reserved bits read back as written
    always_comb begin
        int unsigned s;
        s = rd_sel(page);
        next_rdata = 32'h0000_0000;
        if (dp_map) begin
            case (dp_idx)
                IDX_PAGE:  next_rdata[7:0] = page;
                IDX_CTRL:  next_rdata[7:0] = {run_en,
                                              c_ctrl[7*s +: 7]};
                IDX_STAT: begin
                    next_rdata[STAT_ACTIVE_BIT] = c_active[s];
                    next_rdata[STAT_FAIL_BIT]   = c_fail[s];
                    next_rdata[STAT_DONE_BIT]   = c_done[s];
                end
                IDX_FSC:   next_rdata[7:0] = c_fsc[8*s +: 8];
                IDX_TUNE:  next_rdata[7:0] = tune;
                IDX_CLKG:  next_rdata[7:0] = clkg;
                IDX_OSC:   next_rdata[7:0] = osc;
                IDX_ISTAT: next_rdata[2*NCONV-1:0] = istat;
                IDX_IMASK: next_rdata[2*NCONV-1:0] = imask;
                default:   next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Capture during the read wait state
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            HRDATA <= 32'h0000_0000;
        end else if (dp_rd && !rd_done) begin
            HRDATA <= next_rdata;
        end
    end

    // -----------------------------------------------------------
    // Outputs to the analog side
    // -----------------------------------------------------------

    assign ENGINE_RESET_N = run_en;
    assign CAL_RUN        = c_active;
    assign FSC_CODE       = c_fsc;
    assign CAL_TUNE       = {tune[TUNE_A_BIT], tune[TUNE_B_BIT],
                             tune[TUNE_C_BIT]};
    // Gating is a plain request, software times it
    assign CALCLK_OFF     = clkg[NCONV-1:0];
    assign OSC_CTRL       = osc[OSC_CTRL_BIT];

    // Mode field per converter
    generate
        for (genvar j = 0; j < NCONV; j++) begin : g_mode
            assign CAL_MODE[2*j +: 2] =
                c_ctrl[7*j+CTRL_MODE_LSB +: 2];
        end
    endgenerate
endmodule : ccc_top

/* testbench/ccc_top_sva.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Port checker for the calibration bank
// ---------------------------------------------------------------
module ccc_top_sva
    import ccc_pkg::*;
#(
    parameter int NCONV = 2,  // Converter count
    parameter int AW    = 12  // Bus address width
)(
    input wire logic             CLK,
    input wire logic             ARST_N,
    input wire logic             HSEL,
    input wire logic [AW-1:0]    HADDR,
    input wire logic [1:0]       HTRANS,
    input wire logic             HWRITE,
    input wire logic [31:0]      HWDATA,
    input wire logic             HREADY,
    input wire logic             HREADYOUT,
    input wire logic             ENGINE_RESET_N,
    input wire logic [NCONV-1:0] CAL_RUN,
    input wire logic [NCONV-1:0] CAL_END_OK,
    input wire logic [NCONV-1:0] CAL_END_FAIL,
    input wire logic [2:0]       CAL_TUNE,
    input wire logic [NCONV-1:0] CALCLK_OFF,
    input wire logic [5:0]       OSC_DIV
);
    localparam logic [AW-1:0] A_CTRL = AW'({IDX_CTRL, 2'h0}); // Control
    localparam logic [AW-1:0] A_TUNE = AW'({IDX_TUNE, 2'h0}); // Tuning
    localparam logic [AW-1:0] A_CLKG = AW'({IDX_CLKG, 2'h0}); // Gating
    localparam logic [AW-1:0] A_OSC  = AW'({IDX_OSC, 2'h0});  // Oscillator
    logic          wr_q; // Write data phase in progress
    logic [AW-1:0] a_q;  // Address of that phase

    // Track write data phases; address held while bus stalls
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_q <= 1'b0;
            a_q  <= '0;
        end else if (HREADY) begin
            wr_q <= HSEL && HTRANS[1] && HWRITE;
            a_q  <= HADDR;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    chk_run_enable: assert property (
        wr_q && a_q == A_CTRL |=> ENGINE_RESET_N == $past(HWDATA[7]))
        else $error("engine enable differs from written bit");
    chk_engine_idle: assert property (
        !ENGINE_RESET_N ##1 !ENGINE_RESET_N |-> CAL_RUN == '0)
        else $error("run seen while engine held in reset");
    chk_divide_code: assert property (
        wr_q && a_q == A_OSC && !HWDATA[1]
        |-> ##2 OSC_DIV == ($past(HWDATA[0], 2) ? 6'h10 : 6'h08))
        else $error("oscillator divide ratio wrong");
    chk_tune_bits: assert property (
        wr_q && a_q == A_TUNE |=> CAL_TUNE ==
        {$past(HWDATA[6]), $past(HWDATA[5]), $past(HWDATA[3])})
        else $error("tuning outputs differ from written bits");
    chk_clock_off: assert property (
        wr_q && a_q == A_CLKG |=> CALCLK_OFF == $past(HWDATA[1:0]))
        else $error("clock gating outputs differ from write");
    chk_end_ok: assert property (
        CAL_RUN[0] && $rose(CAL_END_OK[0]) |-> CAL_RUN[0][*3] ##1 !CAL_RUN[0])
        else $error("run did not end three cycles after finish");
    chk_end_fail: assert property (
        CAL_RUN[1] && $rose(CAL_END_FAIL[1])
        |-> CAL_RUN[1][*3] ##1 !CAL_RUN[1])
        else $error("run did not end three cycles after failure");
    chk_read_wait: assert property (
        HSEL && HTRANS[1] && HREADY && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state not exactly one cycle");

    cover property ($rose(CAL_RUN[0]));
    cover property (CAL_RUN[1] && $rose(CAL_END_FAIL[1]));
    cover property (!ENGINE_RESET_N ##1 !ENGINE_RESET_N);
endmodule : ccc_top_sva

/* testbench/tb_ccc_top.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Self-checking bench for the calibration bank
// ---------------------------------------------------------------
module tb_ccc_top;
    import ccc_pkg::*;
    localparam logic [11:0] A_PAGE = {2'h0, IDX_PAGE, 2'h0};
    localparam logic [11:0] A_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [11:0] A_STAT = {2'h0, IDX_STAT, 2'h0};
    localparam logic [11:0] A_FSC  = {2'h0, IDX_FSC, 2'h0};
    localparam logic [11:0] A_TUNE = {2'h0, IDX_TUNE, 2'h0};
    localparam logic [11:0] A_CLKG = {2'h0, IDX_CLKG, 2'h0};
    localparam logic [11:0] A_OSC  = {2'h0, IDX_OSC, 2'h0};
    localparam logic [11:0] A_IST  = {2'h0, IDX_ISTAT, 2'h0};
    localparam logic [11:0] A_MSK  = {2'h0, IDX_IMASK, 2'h0};
    logic        clk    = 1'b0;  // 250 MHz clock
    logic        arst_n = 1'b0;  // Reset, low at start
    logic        hsel   = 1'b0;
    logic [11:0] haddr  = '0;
    logic [1:0]  htrans = '0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic        hready;         // Single slave: ready loops back
    logic        hresp;
    logic        eng, oscc, irq;
    logic [1:0]  run, off;
    logic [1:0]  ok     = '0;    // End pins driven by the bench
    logic [1:0]  fl     = '0;
    logic [3:0]  mode;
    logic [15:0] fsc;
    logic [2:0]  tune;
    logic [5:0]  odiv;
    int          n_mismatch = 0;
    int          cmp_count  = 0;

    always #2 clk = ~clk;

    ccc_top uut (.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .ENGINE_RESET_N(eng), .CAL_RUN(run), .CAL_END_OK(ok),
        .CAL_END_FAIL(fl), .CAL_MODE(mode), .FSC_CODE(fsc), .CAL_TUNE(tune),
        .CALCLK_OFF(off), .OSC_CTRL(oscc), .OSC_DIV(odiv), .IRQ(irq));

    task automatic test_done;
        $display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One single transfer; ready is judged from its pre-edge value
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [7:0] d, output logic [31:0] q);
        int   n;
        logic rdy;
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin
                @(negedge clk);
                rdy = hready;
                q   = hrdata;
                @(posedge clk);
                n++;
            end while (rdy !== 1'b1 && n < 20);
            if (rdy !== 1'b1) begin
                n_mismatch++;
                test_done();
            end
            if (p == 0) begin
                htrans <= 2'h0;
                hsel   <= 1'b0;
                hwdata <= {24'h0, d};
            end
        end
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(a, 1'b0, 8'h00, q);
        chk(q, exp);
    endtask : rd_chk

    // Hold an end pin long enough for sync, flag and interrupt
    task automatic pulse(input logic f, input int c);
        @(posedge clk);
        if (f) begin
            fl[c] <= 1'b1;
        end else begin
            ok[c] <= 1'b1;
        end
        repeat (6) @(posedge clk);
        ok <= 2'b00;
        fl <= 2'b00;
    endtask : pulse

    task automatic t_reset;
        rd_chk(A_CTRL, 32'h82);
        rd_chk(A_STAT, 32'h00);
        rd_chk(A_FSC, 32'h28);
        rd_chk(A_TUNE, 32'h60);
        rd_chk(A_OSC, 32'h02);
        @(negedge clk);
        chk(mode, 32'h5);
        chk(odiv, 32'h20);
        $display("test reset values done");
    endtask : t_reset

    task automatic t_ok;
        wr(A_PAGE, 8'h01);
        wr(A_MSK, 8'h01);
        wr(A_CTRL, 8'h83);
        @(negedge clk);
        chk(run, 32'h1);
        rd_chk(A_STAT, 32'h04);
        pulse(1'b0, 0);
        rd_chk(A_STAT, 32'h01);
        @(negedge clk);
        chk(irq, 32'h1);
        wr(A_IST, 8'h01);
        @(negedge clk);
        chk(irq, 32'h0);
        $display("test run finish done");
    endtask : t_ok

    task automatic t_fail;
        wr(A_PAGE, 8'h02);
        wr(A_MSK, 8'h08);
        wr(A_CTRL, 8'h83);
        @(negedge clk);
        chk(run, 32'h2);
        pulse(1'b1, 1);
        rd_chk(A_STAT, 32'h02);
        @(negedge clk);
        chk(irq, 32'h1);
        wr(A_PAGE, 8'h01);
        rd_chk(A_STAT, 32'h01);
        wr(A_IST, 8'h08);
        @(negedge clk);
        chk(irq, 32'h0);
        $display("test run failure done");
    endtask : t_fail

    task automatic t_enable;
        wr(A_CTRL, 8'h03);
        @(negedge clk);
        chk(eng, 32'h0);
        rd_chk(A_CTRL, 32'h03);
        chk(run, 32'h0);
        wr(A_CTRL, 8'h82);
        @(negedge clk);
        chk(eng, 32'h1);
        $display("test run enable done");
    endtask : t_enable

    task automatic t_fields;
        for (int i = 0; i < 2; i++) begin
            wr(A_OSC, 8'h80 | 8'(i));
            repeat (2) @(negedge clk);
            chk({oscc, odiv}, (i == 0) ? 32'h48 : 32'h50);
        end
        wr(A_PAGE, 8'h02);
        wr(A_FSC, 8'hC5);
        @(negedge clk);
        chk(fsc, 32'hC528);
        rd_chk(A_FSC, 32'hC5);
        wr(A_TUNE, 8'h68);
        wr(A_CLKG, 8'h03);
        @(negedge clk);
        chk(tune, 32'h7);
        chk(off, 32'h3);
        rd_chk(12'h3FC, 32'h0);
        chk(hresp, 32'h0);
        $display("test fields done");
    endtask : t_fields

    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_ok();
        t_fail();
        t_enable();
        t_fields();
        test_done();
    end
endmodule : tb_ccc_top

bind ccc_top ccc_top_sva #(.NCONV(NCONV), .AW(AW)) u_sva (.CLK(CLK),
    .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .ENGINE_RESET_N(ENGINE_RESET_N),
    .CAL_RUN(CAL_RUN), .CAL_END_OK(CAL_END_OK), .CAL_END_FAIL(CAL_END_FAIL),
    .CAL_TUNE(CAL_TUNE), .CALCLK_OFF(CALCLK_OFF), .OSC_DIV(OSC_DIV));
